// File: verilog/afm_params.svh
// Constants for the AES3 frame and mono-mode data path.
// Functional notes
// RL1 - Boundary input high over four master clock rises restarts frame
// RL2 - Boundary output: align to received frame starts
// RL3 - Slave serial source: A sub-frame at word edge
// RL4 - Line drivers grounded: reset, no clock, off bit
// RL5 - Mute bit zeroes transmitted audio immediately
// RL6 - Receive and transmit mono have separate bits
// RL7 - Receive mono: output words at twice frame rate
// RL8 - Receive mono doubles recovered clock rate
// RL9 - Receive mono copies each sub-frame to both fields
// RL10 - Stereo: A and B form one output word
// RL11 - Transmit mono: frame rate is half input rate
// RL12 - Transmit mono selects channel and status block
// RL13 - Serial output and transmitter share one rate
// RL14 - Receive reference clock is the output word clock
// RL15 - User bits change at reference clock edges
// RL16 - Transmit reference: frame rate, doubled in mono
// RL17 - Reference equals input word clock, polarity applied
// RL18 - Input format bit settings chosen by software
// RL19 - Output format bit settings chosen by software
// RL20 - Word length taken from counted bit clocks
// RL21 - Passthrough: master clock only to recovered pin
// RL22 - Transmit through recovery loop: clock pins input
// RL23 - Boundary pin direction set by control bit
`ifndef AFM_PARAMS_SVH
`define AFM_PARAMS_SVH
`define AFM_A_CTRL 4'h0
`define AFM_A_ROUTE 4'h1
`define AFM_A_INFMT 4'h2
`define AFM_A_OUTFMT 4'h3
`define AFM_A_STATUS 4'h4
`define AFM_A_WLEN 4'h5
`define AFM_C_BND_OUT 0
`define AFM_C_TXOFF 1
`define AFM_C_MUTE 2
`define AFM_C_RX_MONO 3
`define AFM_C_TX_MONO 4
`define AFM_C_MONO_RIGHT 5
`define AFM_C_MONO_CS_B 6
`define AFM_C_PASS 7
`define AFM_R_FROM_RX 0
`define AFM_R_VIA_PLL 1
`define AFM_R_RX_MUX 2
`define AFM_F_POL 0
`define AFM_F_MASTER 7
`define AFM_BND_EDGES 3'h4
`define AFM_BLOCK_LAST 8'hbf
`define AFM_CLK_MHZ 50
`define AFM_TXCLK_TIMEOUT_NS 1000
`define AFM_TXCLK_CYC ((`AFM_TXCLK_TIMEOUT_NS * `AFM_CLK_MHZ) / 1000)
`define AFM_WCLK_HALF 6'h3f
`endif

// File: verilog/afm_pkg.sv
// Types for the AES3 frame and mono-mode data path.
package afm_pkg;
    typedef logic [23:0] afm_sample_t;
    typedef struct packed {
        afm_sample_t left;
        afm_sample_t right;
    } afm_pair_s;
endpackage

// File: verilog/afm_mono_path.sv
// AES3 frame boundary control, line driver gating and mono routing.
`timescale 1ns/10ps
`default_nettype none
`include "afm_params.svh"
module afm_mono_path (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic ext_master_clock_in,
    input wire logic block_boundary_pin_in,
    output logic block_boundary_pin_out,
    output logic block_boundary_pin_oe_n_out,
    input wire logic in_word_clock_in,
    input wire logic in_bit_clock_in,
    output logic in_word_clock_out,
    output logic in_bit_clock_out,
    output logic in_clocks_oe_n_out,
    input wire logic rx_frame_start_in,
    input wire logic rx_sub_valid_in,
    input wire logic rx_sub_b_in,
    input wire afm_pkg::afm_sample_t rx_sub_data_in,
    output logic out_word_valid_out,
    output afm_pkg::afm_pair_s out_word_out,
    output logic out_word_clock_out,
    input wire logic tx_in_valid_in,
    input wire afm_pkg::afm_pair_s tx_in_word_in,
    output logic tx_frame_valid_out,
    output afm_pkg::afm_pair_s tx_frame_out,
    output logic tx_frame_start_out,
    output logic tx_block_start_out,
    output logic tx_cs_block_b_out,
    output logic virtual_word_clock_out,
    input wire logic tx_bit_in,
    output logic line_driver_pos_out,
    output logic line_driver_neg_out,
    input wire logic rx_pll_clock_in,
    output logic recovered_master_clock_out,
    output logic recovered_master_clock_oe_n_out,
    output logic rx_clock_mux_select_out,
    output logic rec_clk_double_out
);

    // ***********************************************
    // Register port
    // ***********************************************
    logic [7:0] ctrl_q;
    logic [7:0] route_q;
    logic [7:0] infmt_q;
    logic [7:0] outfmt_q;
    logic [7:0] wlen_q;
    logic [7:0] status_d;
    logic txclk_ok_q;
    logic bnd_lvl;

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ctrl_q <= 8'h00;
            route_q <= 8'h00;
            infmt_q <= 8'h00;
            outfmt_q <= 8'h00;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `AFM_A_CTRL) begin
                ctrl_q <= reg_wdata_in;
            end else if (reg_addr_in == `AFM_A_ROUTE) begin
                route_q <= reg_wdata_in;
            end else if (reg_addr_in == `AFM_A_INFMT) begin
                infmt_q <= reg_wdata_in;
            end else if (reg_addr_in == `AFM_A_OUTFMT) begin
                outfmt_q <= reg_wdata_in;
            end
        end
    end

    logic bnd_out;
    logic txoff;
    logic mute;
    logic rx_mono;
    logic tx_mono;
    logic mono_right;
    logic pass;
    logic from_rx;
    logic via_pll;
    logic in_master;
    logic in_pol;
    assign bnd_out = ctrl_q[`AFM_C_BND_OUT];
    assign txoff = ctrl_q[`AFM_C_TXOFF];
    assign mute = ctrl_q[`AFM_C_MUTE];
    assign rx_mono = ctrl_q[`AFM_C_RX_MONO];
    assign tx_mono = ctrl_q[`AFM_C_TX_MONO];
    assign mono_right = ctrl_q[`AFM_C_MONO_RIGHT];
    assign pass = ctrl_q[`AFM_C_PASS];
    assign from_rx = route_q[`AFM_R_FROM_RX];
    assign via_pll = route_q[`AFM_R_VIA_PLL];
    assign in_master = infmt_q[`AFM_F_MASTER];
    assign in_pol = infmt_q[`AFM_F_POL];
    assign status_d = {6'h00, bnd_lvl, txclk_ok_q};

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            reg_rdata_out <= 8'h00;
        end else if (!reg_rd_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_addr_in == `AFM_A_CTRL) begin
            reg_rdata_out <= ctrl_q;
        end else if (reg_addr_in == `AFM_A_ROUTE) begin
            reg_rdata_out <= route_q;
        end else if (reg_addr_in == `AFM_A_INFMT) begin
            reg_rdata_out <= infmt_q;
        end else if (reg_addr_in == `AFM_A_OUTFMT) begin
            reg_rdata_out <= outfmt_q;
        end else if (reg_addr_in == `AFM_A_STATUS) begin
            reg_rdata_out <= status_d;
        end else if (reg_addr_in == `AFM_A_WLEN) begin
            reg_rdata_out <= wlen_q;
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // ***********************************************
    // Pin synchronisers
    // ***********************************************
    // Stage one feeds stage two only; stages two and three give edges.
    logic [3:0] pin_raw;
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] s3_q;
    assign pin_raw = {in_bit_clock_in, in_word_clock_in,
                      block_boundary_pin_in, ext_master_clock_in};

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            s1_q <= 4'h0;
            s2_q <= 4'h0;
            s3_q <= 4'h0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    logic mclk_rise;
    logic iwc_lvl;
    logic iwc_edge;
    logic iwc_lead;
    logic ibc_rise;
    assign mclk_rise = s2_q[0] & ~s3_q[0];
    assign bnd_lvl = s2_q[1];
    assign iwc_lvl = s2_q[2];
    assign iwc_edge = s2_q[2] ^ s3_q[2];
    assign iwc_lead = iwc_edge & (s2_q[2] ^ in_pol);
    assign ibc_rise = s2_q[3] & ~s3_q[3];

    // ***********************************************
    // Transmit clock watchdog and line drivers
    // ***********************************************
    logic [7:0] idle_q;
    always_ff @(posedge core_clk_in) begin
        if (reset_in || mclk_rise) begin
            idle_q <= 8'h00;
        end else if (idle_q != 8'(`AFM_TXCLK_CYC)) begin
            idle_q <= idle_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            txclk_ok_q <= 1'b0;
        end else begin
            txclk_ok_q <= (idle_q != 8'(`AFM_TXCLK_CYC));
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in || !txclk_ok_q || txoff) begin // RL4
            line_driver_pos_out <= 1'b0;
            line_driver_neg_out <= 1'b0;
        end else begin
            line_driver_pos_out <= tx_bit_in;
            line_driver_neg_out <= ~tx_bit_in;
        end
    end

    // ***********************************************
    // Frame and block boundaries
    // ***********************************************
    logic [2:0] bnd_cnt_q;
    logic bnd_fire;
    always_ff @(posedge core_clk_in) begin
        if (reset_in || !bnd_lvl || bnd_out) begin
            bnd_cnt_q <= 3'h0;
        end else if (mclk_rise && bnd_cnt_q != `AFM_BND_EDGES) begin
            bnd_cnt_q <= bnd_cnt_q + 3'h1;
        end
    end
    assign bnd_fire = mclk_rise && (bnd_cnt_q == `AFM_BND_EDGES - 3'h1)
                      && bnd_lvl && !bnd_out; // RL1

    logic fs_rx;
    logic fs_sin;
    logic align_mode;
    logic align;
    logic a_phase_q;
    logic frame_emit;
    assign fs_rx = bnd_out && from_rx && rx_frame_start_in; // RL2
    assign fs_sin = bnd_out && !from_rx && !in_master && iwc_lead; // RL3
    assign align_mode = bnd_out; // RL23
    assign align = bnd_fire || fs_rx || fs_sin;

    logic [7:0] frame_q;
    logic frame_start;
    assign frame_start = align || (!align_mode && frame_emit);
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            frame_q <= 8'h00;
        end else if (bnd_fire) begin // RL1
            frame_q <= 8'h00;
        end else if (frame_start) begin
            frame_q <= (frame_q == `AFM_BLOCK_LAST) ? 8'h00
                       : frame_q + 8'h01;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            tx_frame_start_out <= 1'b0;
            tx_block_start_out <= 1'b0;
            block_boundary_pin_out <= 1'b0;
        end else begin
            tx_frame_start_out <= frame_start;
            tx_block_start_out <= bnd_fire ||
                (frame_start && frame_q == `AFM_BLOCK_LAST);
            block_boundary_pin_out <= frame_start &&
                frame_q == `AFM_BLOCK_LAST;
        end
    end
    assign block_boundary_pin_oe_n_out = ~bnd_out; // RL23

    // ***********************************************
    // Transmit sample packing
    // ***********************************************
    afm_pkg::afm_sample_t pick;
    afm_pkg::afm_sample_t a_hold_q;
    assign pick = mono_right ? tx_in_word_in.right
                             : tx_in_word_in.left; // RL12
    assign frame_emit = tx_in_valid_in && (!tx_mono || !a_phase_q);

    always_ff @(posedge core_clk_in) begin
        if (reset_in || align) begin
            a_phase_q <= 1'b1;
        end else if (tx_in_valid_in && tx_mono) begin // RL11
            a_phase_q <= ~a_phase_q;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            a_hold_q <= 24'h000000;
        end else if (tx_in_valid_in && tx_mono && a_phase_q) begin
            a_hold_q <= pick;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            tx_frame_valid_out <= 1'b0;
            tx_frame_out <= '0;
        end else begin
            tx_frame_valid_out <= frame_emit;
            if (frame_emit && mute) begin // RL5
                tx_frame_out <= '0;
            end else if (frame_emit && tx_mono) begin // RL6
                tx_frame_out <= {a_hold_q, pick};
            end else if (frame_emit) begin
                tx_frame_out <= tx_in_word_in;
            end
        end
    end
    assign tx_cs_block_b_out = tx_mono && ctrl_q[`AFM_C_MONO_CS_B];

    // ***********************************************
    // Reference word clocks and serial input timing
    // ***********************************************
    logic ref_tog_q;
    logic follow_iwc;
    assign follow_iwc = in_master ^ bnd_out;
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            ref_tog_q <= 1'b0;
        end else if (tx_mono ? tx_in_valid_in : frame_emit) begin // RL16
            ref_tog_q <= ~ref_tog_q;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            virtual_word_clock_out <= 1'b0;
        end else if (follow_iwc) begin
            virtual_word_clock_out <= iwc_lvl ^ in_pol; // RL17
        end else begin
            virtual_word_clock_out <= ref_tog_q;
        end
    end

    logic [7:0] bit_cnt_q;
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            bit_cnt_q <= 8'h00;
            wlen_q <= 8'h00;
        end else if (iwc_edge) begin // RL20
            wlen_q <= bit_cnt_q;
            bit_cnt_q <= {7'h00, ibc_rise};
        end else if (ibc_rise && bit_cnt_q != 8'hff) begin
            bit_cnt_q <= bit_cnt_q + 8'h01;
        end
    end

    logic [5:0] mdiv_q;
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            mdiv_q <= 6'h00;
            in_bit_clock_out <= 1'b0;
            in_word_clock_out <= 1'b0;
        end else if (mclk_rise) begin
            in_bit_clock_out <= ~in_bit_clock_out;
            mdiv_q <= mdiv_q + 6'h01;
            if (mdiv_q == `AFM_WCLK_HALF) begin
                in_word_clock_out <= ~in_word_clock_out;
            end
        end
    end
    assign in_clocks_oe_n_out = ~(in_master && !via_pll); // RL22

    // ***********************************************
    // Receive routing to the serial output
    // ***********************************************
    afm_pkg::afm_sample_t rx_a_q;
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rx_a_q <= 24'h000000;
        end else if (rx_sub_valid_in && !rx_sub_b_in) begin
            rx_a_q <= rx_sub_data_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            out_word_valid_out <= 1'b0;
            out_word_out <= '0;
            out_word_clock_out <= 1'b0;
        end else if (rx_sub_valid_in && rx_mono) begin // RL7
            out_word_valid_out <= 1'b1;
            out_word_out <= {rx_sub_data_in, rx_sub_data_in}; // RL9
            out_word_clock_out <= ~out_word_clock_out; // RL14
        end else if (rx_sub_valid_in && rx_sub_b_in) begin
            out_word_valid_out <= 1'b1;
            out_word_out <= {rx_a_q, rx_sub_data_in}; // RL10
            out_word_clock_out <= ~out_word_clock_out;
        end else begin
            out_word_valid_out <= 1'b0;
        end
    end

    // ***********************************************
    // Recovered clock pin
    // ***********************************************
    logic rxc_s1_q;
    logic rxc_s2_q;
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            rxc_s1_q <= 1'b0;
            rxc_s2_q <= 1'b0;
            recovered_master_clock_out <= 1'b0;
        end else begin
            rxc_s1_q <= rx_pll_clock_in;
            rxc_s2_q <= rxc_s1_q;
            recovered_master_clock_out <= pass ? s2_q[0] : rxc_s2_q;
        end
    end
    assign rx_clock_mux_select_out = route_q[`AFM_R_RX_MUX] && !pass; // RL21
    assign recovered_master_clock_oe_n_out =
        ~(pass || route_q[`AFM_R_RX_MUX]);
    assign rec_clk_double_out = rx_mono; // RL8

    // ***********************************************
    // Assertions
    // ***********************************************
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    a_bnd_input_start: assert property (bnd_fire |=> tx_frame_start_out
        && tx_block_start_out) else $error("boundary start lost"); // RL1
    a_rx_frame_align: assert property (fs_rx |=> tx_frame_start_out)
        else $error("rx frame not aligned"); // RL2
    a_sin_frame_align: assert property (fs_sin |=> tx_frame_start_out
        && a_phase_q)
        else $error("serial frame not aligned"); // RL3
    a_line_grounded: assert property ((txoff || !txclk_ok_q) |=>
        !line_driver_pos_out && !line_driver_neg_out)
        else $error("line driver not grounded"); // RL4
    a_mute_zero: assert property ($past(mute) && tx_frame_valid_out |->
        tx_frame_out == '0) else $error("muted data nonzero"); // RL5
    a_rx_mono_copy: assert property (rx_mono && rx_sub_valid_in |=>
        out_word_valid_out && out_word_out.left == out_word_out.right
        && out_word_out.left == $past(rx_sub_data_in))
        else $error("mono copy wrong"); // RL9
    a_pass_mux_off: assert property (pass |-> !rx_clock_mux_select_out
        && !recovered_master_clock_oe_n_out)
        else $error("passthrough routing wrong"); // RL21
    a_pll_pins_input: assert property (via_pll |-> in_clocks_oe_n_out)
        else $error("clock pins driven"); // RL22
    a_ref_follows_iwc: assert property (follow_iwc ##1 follow_iwc |->
        virtual_word_clock_out == $past(iwc_lvl ^ in_pol))
        else $error("reference clock wrong"); // RL17

endmodule
`default_nettype wire

// File: sim/afm_far_model.sv
// Far-side model: master clock, encoder bit and serial port clocks.
`timescale 1ns/10ps
`default_nettype none
module afm_far_model (
    input wire logic core_clk_in,
    input wire logic mclk_run_in,
    output logic ext_master_clock_out,
    output logic rx_pll_clock_out,
    output logic tx_bit_out,
    output logic in_word_clock_out,
    output logic in_bit_clock_out
);
    // ********************************************
    // Clock sources.
    // ********************************************
    initial begin
        ext_master_clock_out = 1'b0;
        rx_pll_clock_out = 1'b0;
        tx_bit_out = 1'b0;
        in_word_clock_out = 1'b0;
        in_bit_clock_out = 1'b0;
        #7;
        forever begin
            #80;
            if (mclk_run_in) begin
                ext_master_clock_out = ~ext_master_clock_out;
            end
        end
    end
    always #37 rx_pll_clock_out = ~rx_pll_clock_out;
    always @(posedge core_clk_in) tx_bit_out <= ~tx_bit_out;
    task set_word(input logic v);
        in_word_clock_out = v;
    endtask
    task serial_word(input int n);
        repeat (n) begin
            in_bit_clock_out = 1'b0;
            #80;
            in_bit_clock_out = 1'b1;
            #80;
        end
        in_bit_clock_out = 1'b0;
        #40;
        in_word_clock_out = ~in_word_clock_out;
        #40;
    endtask
endmodule
`default_nettype wire

// File: sim/afm_mono_path_bench.sv
// Self-checking bench for the AES3 frame and mono-mode data path.
`timescale 1ns/10ps
`default_nettype none
`include "afm_params.svh"
module afm_mono_path_bench;
    logic core_clk_in, reset_in, reg_wr_in, reg_rd_in, mclk_run, rd_pend;
    logic [3:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out;
    logic ext_master_clock_in, block_boundary_pin_in, in_word_clock_in;
    logic in_bit_clock_in, rx_frame_start_in, rx_sub_valid_in, rx_sub_b_in;
    logic tx_in_valid_in, tx_bit_in, rx_pll_clock_in, tx_block_start_out;
    logic block_boundary_pin_out, block_boundary_pin_oe_n_out;
    logic in_clocks_oe_n_out, out_word_valid_out, tx_frame_valid_out;
    logic tx_frame_start_out, tx_cs_block_b_out, virtual_word_clock_out;
    logic line_driver_pos_out, line_driver_neg_out, rx_clock_mux_select_out;
    logic recovered_master_clock_oe_n_out, rec_clk_double_out;
    afm_pkg::afm_sample_t rx_sub_data_in, d1, d2;
    afm_pkg::afm_pair_s tx_in_word_in, out_word_out, tx_frame_out, w1, w2;
    logic [47:0] rdq[$], txq[$], rxq[$];
    logic [7:0] fmt[4] = '{8'h00, 8'h05, 8'h88, 8'h30};
    logic [7:0] txc[4] = '{8'h00, 8'h04, 8'h10, 8'h30};
    logic [7:0] rt[3] = '{8'h06, 8'h04, 8'h00};
    logic [7:0] ct[3] = '{8'h80, 8'h00, 8'h00};
    logic [2:0] pins[3] = '{3'h4, 3'h2, 3'h1};
    int errors, num_checks, cycles, nfr, nblk, npin, n, k, i;

    afm_mono_path uut (
        .core_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .ext_master_clock_in,
        .block_boundary_pin_in, .block_boundary_pin_out,
        .block_boundary_pin_oe_n_out, .in_word_clock_in, .in_bit_clock_in,
        .in_word_clock_out(), .in_bit_clock_out(), .in_clocks_oe_n_out,
        .rx_frame_start_in, .rx_sub_valid_in, .rx_sub_b_in, .rx_sub_data_in,
        .out_word_valid_out, .out_word_out, .out_word_clock_out(),
        .tx_in_valid_in, .tx_in_word_in, .tx_frame_valid_out, .tx_frame_out,
        .tx_frame_start_out, .tx_block_start_out, .tx_cs_block_b_out,
        .virtual_word_clock_out, .tx_bit_in, .line_driver_pos_out,
        .line_driver_neg_out, .rx_pll_clock_in, .recovered_master_clock_out(),
        .recovered_master_clock_oe_n_out, .rx_clock_mux_select_out,
        .rec_clk_double_out
    );
    afm_far_model far (
        .core_clk_in, .mclk_run_in(mclk_run),
        .ext_master_clock_out(ext_master_clock_in),
        .rx_pll_clock_out(rx_pll_clock_in), .tx_bit_out(tx_bit_in),
        .in_word_clock_out(in_word_clock_in),
        .in_bit_clock_out(in_bit_clock_in)
    );

    initial core_clk_in = 1'b0;
    always #10 core_clk_in = ~core_clk_in;

    // ********************************************
    // Shared tasks and the output watcher.
    // ********************************************
    task automatic chk(input string nm, input logic [47:0] e, g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task wait_n(input int c);
        repeat (c) @(posedge core_clk_in);
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
        @(posedge core_clk_in);
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        rdq.push_back({40'h0, e});
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        @(posedge core_clk_in);
    endtask
    task txw(input afm_pkg::afm_pair_s w);
        tx_in_word_in <= w;
        tx_in_valid_in <= 1'b1;
        @(posedge core_clk_in);
        tx_in_valid_in <= 1'b0;
        @(posedge core_clk_in);
    endtask
    task rxs(input logic b, input afm_pkg::afm_sample_t d);
        rx_sub_b_in <= b;
        rx_sub_data_in <= d;
        rx_sub_valid_in <= 1'b1;
        @(posedge core_clk_in);
        rx_sub_valid_in <= 1'b0;
        @(posedge core_clk_in);
    endtask
    function logic [47:0] drv();
        return 48'({line_driver_pos_out, line_driver_neg_out});
    endfunction
    task drv_live;
        logic b;
        @(posedge core_clk_in);
        b = tx_bit_in;
        @(posedge core_clk_in);
        chk("line_drivers", 48'({b, ~b}), drv());
    endtask

    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        rd_pend <= reg_rd_in;
        if (tx_frame_start_out) nfr <= nfr + 1;
        if (tx_block_start_out) nblk <= nblk + 1;
        if (block_boundary_pin_out) npin <= npin + 1;
        if (rd_pend) chk("reg_rdata", rdq.size() > 0 ? rdq.pop_front()
            : 48'hx, {40'h0, reg_rdata_out});
        if (tx_frame_valid_out) chk("tx_frame", txq.size() > 0
            ? txq.pop_front() : 48'hx, tx_frame_out);
        if (out_word_valid_out) chk("out_word", rxq.size() > 0
            ? rxq.pop_front() : 48'hx, out_word_out);
        if (cycles == 10000) begin
            errors++;
            report_and_stop();
        end
    end

    // ********************************************
    // Scenarios.
    // ********************************************
    initial begin
        void'($urandom(39337));
        {reg_wr_in, reg_rd_in, tx_in_valid_in, rx_sub_valid_in} = 4'h0;
        {rx_frame_start_in, rx_sub_b_in, block_boundary_pin_in} = 3'h0;
        {reg_addr_in, reg_wdata_in, rx_sub_data_in} = 36'h0;
        tx_in_word_in = 48'h0;
        {rd_pend, mclk_run, reset_in} = 3'h3;
        repeat (2) @(posedge core_clk_in);
        chk("drv_reset", 48'h0, drv());
        reset_in <= 1'b0;
        wait_n(10);
        rd(`AFM_A_CTRL, 8'h00);
        rd(4'hf, 8'h00);
        wr(`AFM_A_STATUS, 8'hfe);
        rd(`AFM_A_STATUS, 8'h01);
        foreach (fmt[f]) begin
            wr(`AFM_A_INFMT, fmt[f] & 8'h7f);
            wr(`AFM_A_OUTFMT, fmt[f]);
            rd(`AFM_A_INFMT, fmt[f] & 8'h7f);
            rd(`AFM_A_OUTFMT, fmt[f]);
        end
        wr(`AFM_A_CTRL, 8'h02);
        wait_n(2);
        chk("drv_off", 48'h0, drv());
        wr(`AFM_A_CTRL, 8'h00);
        drv_live();
        mclk_run <= 1'b0;
        wait_n(70);
        chk("drv_noclk", 48'h0, drv());
        rd(`AFM_A_STATUS, 8'h00);
        mclk_run <= 1'b1;
        wait_n(20);
        drv_live();
        foreach (txc[t]) begin
            wr(`AFM_A_CTRL, txc[t]);
            w1 = {16'($urandom()), $urandom()};
            w2 = {16'($urandom()), $urandom()};
            if (txc[t][4]) begin
                txq.push_back(txc[t][5] ? {w1.right, w2.right}
                    : {w1.left, w2.left});
                txw(w1);
                txw(w2);
            end else begin
                txq.push_back(txc[t][2] ? 48'h0 : w1);
                txw(w1);
            end
        end
        wr(`AFM_A_CTRL, 8'h50);
        chk("cs_block_b", 48'h1, 48'(tx_cs_block_b_out));
        wr(`AFM_A_CTRL, 8'h40);
        chk("cs_block_b", 48'h0, 48'(tx_cs_block_b_out));
        for (i = 0; i < 2; i++) begin
            wr(`AFM_A_CTRL, i ? 8'h08 : 8'h00);
            chk("rx_double", 48'(i), 48'(rec_clk_double_out));
            d1 = 24'($urandom());
            d2 = 24'($urandom());
            if (i) begin
                rxq.push_back({d1, d1});
                rxq.push_back({d2, d2});
            end else begin
                rxq.push_back({d1, d2});
            end
            rxs(1'b0, d1);
            rxs(1'b1, d2);
        end
        w1 = {16'($urandom()), $urandom()};
        txq.push_back(w1);
        txw(w1);
        wr(`AFM_A_CTRL, 8'h00);
        chk("bnd_dir", 48'h1, 48'(block_boundary_pin_oe_n_out));
        n = nblk;
        k = nfr;
        block_boundary_pin_in <= 1'b1;
        wait_n(8);
        block_boundary_pin_in <= 1'b0;
        wait_n(40);
        chk("bnd_short", 48'(n), 48'(nblk));
        block_boundary_pin_in <= 1'b1;
        wait_n(80);
        block_boundary_pin_in <= 1'b0;
        wait_n(40);
        chk("bnd_block", 48'(n + 1), 48'(nblk));
        chk("bnd_frame", 48'(k + 1), 48'(nfr));
        wr(`AFM_A_ROUTE, 8'h01);
        wr(`AFM_A_CTRL, 8'h01);
        chk("bnd_dir", 48'h0, 48'(block_boundary_pin_oe_n_out));
        n = nfr;
        k = npin;
        repeat (192) begin
            rx_frame_start_in <= 1'b1;
            @(posedge core_clk_in);
            rx_frame_start_in <= 1'b0;
            wait_n(2);
        end
        wait_n(4);
        chk("rx_aligned", 48'(n + 192), 48'(nfr));
        chk("block_pin", 48'(k + 1), 48'(npin));
        wr(`AFM_A_ROUTE, 8'h00);
        for (i = 0; i < 2; i++) begin
            wr(`AFM_A_INFMT, 8'(i));
            far.set_word(1'b0);
            wait_n(8);
            n = nfr;
            chk("ref_low", 48'(i), 48'(virtual_word_clock_out));
            far.set_word(1'b1);
            wait_n(8);
            chk("ref_high", 48'(1 - i), 48'(virtual_word_clock_out));
            chk("lead_rise", 48'(n + 1 - i), 48'(nfr));
            far.set_word(1'b0);
            wait_n(8);
            chk("lead_fall", 48'(n + 1), 48'(nfr));
        end
        wr(`AFM_A_INFMT, 8'h05);
        n = 16 + $urandom_range(16);
        repeat (3) far.serial_word(n);
        wait_n(6);
        rd(`AFM_A_WLEN, 8'(n));
        wr(`AFM_A_INFMT, 8'h80);
        foreach (rt[t]) begin
            wr(`AFM_A_ROUTE, rt[t]);
            wr(`AFM_A_CTRL, ct[t]);
            chk("pin_dirs", 48'(pins[t]), 48'({in_clocks_oe_n_out,
                rx_clock_mux_select_out, recovered_master_clock_oe_n_out}));
        end
        wait_n(10);
        chk("pending", 48'h0, 48'(rdq.size() + txq.size() + rxq.size()));
        report_and_stop();
    end
endmodule
`default_nettype wire
